// [rtl/boot_erase_consts.svh]
`ifndef BOOT_ERASE_CONSTS_SVH
`define BOOT_ERASE_CONSTS_SVH
// =============================================
// Command and reply codes
`define CMD_ENTER_PROG   8'h40
`define RSP_ACK          8'h06
`define RSP_ENTER_ERR    8'hC0
`define ERR_ERASE_FAIL   8'h51
// =============================================
// Reply lengths in bytes
`define ACK_REPLY_LEN    2'h1
`define ERR_REPLY_LEN    2'h2
`endif

// [rtl/boot_erase_pkg.sv]
package boot_erase_pkg;
    // =============================================
    // Erase request towards the flash controller
    typedef struct packed {
        logic       start;   // One-cycle start pulse
        logic       boot;    // 0 user array, 1 boot array
    } erase_req_t;

    // Byte for the serial transmitter
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } tx_byte_t;
endpackage : boot_erase_pkg

// [rtl/erase_sequencer.sv]
`timescale 1ns/1ns
module erase_sequencer (
    input  wire logic                      clk_i,        // System clock
    input  wire logic                      sys_rst_i,    // Async reset, high
    input  wire logic                      go_i,         // Start user erasure, boot erasure follows only if it passes
    input  wire logic                      erase_done_i, // Flash erase finished
    input  wire logic                      erase_err_i,  // Flash erase failed
    output boot_erase_pkg::erase_req_t     req_o,        // Erase request
    output logic                           fin_o,        // Sequence finished pulse
    output logic                           fail_o        // Failure with fin_o
);
    typedef enum logic [1:0] {S_IDLE, S_USER, S_BOOT} seq_state_t;
    seq_state_t state_q;

    // =============================================
    // User array first, boot array second
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= S_IDLE;
            req_o   <= '0;
            fin_o   <= 1'b0;
            fail_o  <= 1'b0;
        end else begin
            req_o.start <= 1'b0;
            fin_o       <= 1'b0;
            unique case (state_q)
                S_IDLE: if (go_i) begin
                    state_q     <= S_USER;
                    req_o.start <= 1'b1;
                    req_o.boot  <= 1'b0;
                end
                S_USER: if (erase_done_i) begin
                    if (erase_err_i) begin
                        state_q <= S_IDLE;
                        fin_o   <= 1'b1;
                        fail_o  <= 1'b1;
                    end else begin
                        state_q     <= S_BOOT;
                        req_o.start <= 1'b1;
                        req_o.boot  <= 1'b1;
                    end
                end
                S_BOOT: if (erase_done_i) begin
                    state_q <= S_IDLE;
                    fin_o   <= 1'b1;
                    fail_o  <= erase_err_i;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule : erase_sequencer

// [rtl/boot_erase_transition.sv]
`timescale 1ns/1ns
`include "boot_erase_consts.svh"
module boot_erase_transition (
    input  wire logic                      clk_i,        // System clock 100 MHz
    input  wire logic                      sys_rst_i,    // Async reset, high
    input  wire logic                      rx_valid_i,   // Received byte strobe
    input  wire logic [7:0]                rx_data_i,    // Received byte
    input  wire logic                      tx_ready_i,   // Transmitter takes byte
    output boot_erase_pkg::tx_byte_t       tx_o,         // Reply byte
    output boot_erase_pkg::erase_req_t     erase_o,      // Erase request
    input  wire logic                      erase_done_i, // Erase finished pulse
    input  wire logic                      erase_err_i,  // Erase failed, with done
    output logic                           prog_state_o, // In programming/erasure state
    output logic                           busy_o        // Command in progress
);
    typedef enum logic [2:0] {T_IDLE, T_ERASE, T_ACK, T_ERR0, T_ERR1} top_state_t;
    top_state_t state_q;
    logic       go;
    logic       fin;
    logic       fail;
    boot_erase_pkg::erase_req_t req;
    logic       tx_taken;   // Reply byte leaves this cycle
    logic [1:0] starts_q;   // Erase starts of this command, {boot, user}
    logic [1:0] replies_q;  // Reply bytes taken for this command

    // =============================================
    // Command decode

    // Transition command is a single fixed byte, nothing follows it
    function automatic logic is_enter_cmd(input logic [7:0] code);
        return code == `CMD_ENTER_PROG;
    endfunction : is_enter_cmd

    // Taken only when idle and not yet in the programming/erasure state
    assign go = (state_q == T_IDLE) && !prog_state_o && rx_valid_i
                && is_enter_cmd(rx_data_i);

    // Hand-over of the byte on the reply port
    assign tx_taken = tx_o.valid && tx_ready_i;

    // =============================================
    // Erase sequencing: user array, then boot array

    erase_sequencer u_seq (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .go_i         (go),
        .erase_done_i (erase_done_i),
        .erase_err_i  (erase_err_i),
        .req_o        (req),
        .fin_o        (fin),
        .fail_o       (fail)
    );

    // =============================================
    // Command and reply sequencing

    // Phase of the command: idle, erasing, then one or two reply bytes
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= T_IDLE;
        end else begin
            unique case (state_q)
                T_IDLE: begin
                    if (go) begin
                        state_q <= T_ERASE;
                    end
                end
                T_ERASE: begin
                    if (fin) begin
                        state_q <= fail ? T_ERR0 : T_ACK;
                    end
                end
                T_ACK: begin
                    if (tx_taken) begin
                        state_q <= T_IDLE;
                    end
                end
                T_ERR0: begin
                    if (tx_taken) begin
                        state_q <= T_ERR1;
                    end
                end
                T_ERR1: begin
                    if (tx_taken) begin
                        state_q <= T_IDLE;
                    end
                end
                default: begin
                    state_q <= T_IDLE;
                end
            endcase
        end
    end

    // Reply byte: raised only once erasing is over, held until taken
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_o <= '0;
        end else if (state_q == T_ERASE && fin) begin
            tx_o.valid <= 1'b1;
            tx_o.data  <= fail ? `RSP_ENTER_ERR : `RSP_ACK;
        end else if (state_q == T_ERR0 && tx_taken) begin
            tx_o.data  <= `ERR_ERASE_FAIL;
        end else if (tx_taken) begin
            tx_o.valid <= 1'b0;
        end
    end

    // Programming/erasure state: entered after the acknowledge byte is taken
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prog_state_o <= 1'b0;
        end else if (state_q == T_ACK && tx_taken) begin
            prog_state_o <= 1'b1;
        end
    end

    // Busy from the command byte until the last reply byte is taken
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_o <= 1'b0;
        end else if (go) begin
            busy_o <= 1'b1;
        end else if ((state_q == T_ACK || state_q == T_ERR1) && tx_taken) begin
            busy_o <= 1'b0;
        end
    end

    // Erase request re-timed, so the output leaves a flip-flop of this level
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            erase_o <= '0;
        end else begin
            erase_o <= req;
        end
    end

    // =============================================
    // Bookkeeping for the checks

    // Erase starts issued for the current command
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            starts_q <= 2'h0;
        end else if (go) begin
            starts_q <= 2'h0;
        end else if (erase_o.start) begin
            starts_q[erase_o.boot] <= 1'b1;
        end
    end

    // Reply bytes handed over for the current command
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            replies_q <= 2'h0;
        end else if (go) begin
            replies_q <= 2'h0;
        end else if (tx_taken) begin
            replies_q <= replies_q + 2'h1;
        end
    end

    // =============================================
    // Checks
    chk_silent_erase: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_q == T_ERASE |-> !tx_o.valid) else $error("byte sent during erase");
    chk_user_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        go |=> ##1 (erase_o.start && !erase_o.boot)) else $error("user array not erased first");
    chk_ack_code: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == T_ACK) |-> (tx_o.valid && tx_o.data == `RSP_ACK)) else $error("bad ack");
    chk_ack_enter: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == T_ACK && tx_ready_i) |=> prog_state_o) else $error("no state entry");
    chk_err_pair: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == T_ERR0 && tx_ready_i) |=> (tx_o.valid && tx_o.data == `ERR_ERASE_FAIL))
        else $error("missing error code");
    chk_err_stay: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == T_ERR1 && tx_taken)
            |=> (!prog_state_o && !tx_o.valid && state_q == T_IDLE))
        else $error("entered after error");
    chk_cmd_decode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == T_IDLE && rx_valid_i && rx_data_i != `CMD_ENTER_PROG) |=> state_q == T_IDLE)
        else $error("wrong byte accepted");
    chk_no_early_state: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(prog_state_o) |-> $past(state_q) == T_ACK) else $error("early entry");

    // Both arrays erased, user array first
    chk_boot_after_user: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (erase_o.start && erase_o.boot) |-> starts_q[0]) else $error("boot array first");
    chk_ack_both: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == T_ERASE && fin && !fail) |-> (starts_q == 2'h3))
        else $error("reply without both erasures");
    chk_start_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        erase_o.start |=> !erase_o.start) else $error("erase start not one cycle");

    // Only the transition byte starts a command
    chk_busy_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(busy_o) |-> ($past(rx_valid_i) && $past(rx_data_i) == `CMD_ENTER_PROG))
        else $error("busy without command byte");
    chk_refuse_prog: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (prog_state_o && rx_valid_i) |=> !busy_o) else $error("command taken in state");

    // Reply bytes: held until taken, one ack byte or two error bytes
    chk_reply_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (tx_o.valid && !tx_ready_i) |=> (tx_o.valid && $stable(tx_o.data)))
        else $error("reply byte dropped");
    chk_ack_single: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == T_ACK && tx_taken) |-> ((replies_q + 2'h1) == `ACK_REPLY_LEN))
        else $error("ack not one byte");
    chk_err_length: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == T_ERR1 && tx_taken) |-> ((replies_q + 2'h1) == `ERR_REPLY_LEN))
        else $error("error reply not two bytes");
    chk_busy_end: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == T_ACK && tx_taken) |=> (!busy_o && !tx_o.valid)) else $error("busy after ack");
    chk_silent_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        erase_o.start |-> !tx_o.valid) else $error("byte sent at erase start");

    // Main scenarios
    cov_ack: cover property (@(posedge clk_i) $rose(prog_state_o));
    cov_err: cover property (@(posedge clk_i) state_q == T_ERR1 && tx_ready_i);
    cov_start: cover property (@(posedge clk_i) go);
    cov_user_fail: cover property (@(posedge clk_i)
        state_q == T_ERASE && fin && fail && !starts_q[1]);
    cov_ack_stall: cover property (@(posedge clk_i) state_q == T_ACK && !tx_ready_i);
endmodule : boot_erase_transition

// [tb/flash_erase_model.sv]
`timescale 1ns/1ns
// =============================================
// Flash erase controller stand-in, prompt or slow, may fail
module flash_erase_model (
    input  wire logic                  clk_i,  // System clock
    input  wire logic                  clr_i,  // Clear start history
    input  boot_erase_pkg::erase_req_t req_i,  // Erase request
    input  wire logic [1:0]            fail_i, // Fail {boot,user}
    input  wire logic [7:0]            dly_i,  // Erase time in cycles
    output logic                       done_o, // Erase finished pulse
    output logic                       err_o,  // Erase failed, with done
    output logic                       busy_o, // Erase running
    output logic [3:0]                 hist_o  // Starts as {1,boot}, newest low
);
    logic [7:0] cnt_q;
    logic       boot_q;
    initial {done_o, err_o, busy_o, hist_o, cnt_q, boot_q} = '0;
    // Done only ever follows a start, after the erase time
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        err_o  <= 1'b0;
        if (clr_i) hist_o <= 4'h0;
        if (req_i.start) begin
            busy_o <= 1'b1;
            cnt_q  <= dly_i;
            boot_q <= req_i.boot;
            hist_o <= {hist_o[1:0], 1'b1, req_i.boot};
        end else if (busy_o && cnt_q == 8'h00) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            err_o  <= fail_i[boot_q];
        end else if (busy_o) cnt_q <= cnt_q - 8'h01;
    end
endmodule : flash_erase_model

// [tb/test_boot_erase_state_transition.sv]
`timescale 1ns/1ns
module test_boot_erase_state_transition;
    typedef struct packed {
        logic [1:0] fail; logic [7:0] dly; logic [7:0] b0; logic [7:0] b1;
        logic two; logic prog; logic [3:0] hist;
    } row_t;
    logic clk_i = 0, sys_rst_i = 1, rx_valid_i = 0, tx_ready_i = 0, clr = 0;
    logic [7:0] rx_data_i = 8'h00, dly = 8'h00;
    logic [1:0] fail = 2'b00;
    logic done, err, ebusy, prog_state, busy;
    logic [3:0] hist;
    boot_erase_pkg::tx_byte_t   tx;
    boot_erase_pkg::erase_req_t ereq;
    int fail_count = 0, n_tests = 0;
    // Host selection commands sent first; codes arbitrary, the block ignores them
    localparam logic [7:0] SEL_DEVICE = 8'h21;
    localparam logic [7:0] SEL_CLOCK  = 8'h22;
    localparam logic [7:0] SEL_RATE   = 8'h23;
    // Rows: user fail, slow boot fail, success
    row_t rows [3] = '{'{2'b01, 8'h00, 8'hC0, 8'h51, 1'b1, 1'b0, 4'h2},
                       '{2'b10, 8'h14, 8'hC0, 8'h51, 1'b1, 1'b0, 4'hB},
                       '{2'b00, 8'h02, 8'h06, 8'h00, 1'b0, 1'b1, 4'hB}};
    always #5 clk_i = ~clk_i;
    boot_erase_transition i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_ready_i(tx_ready_i), .tx_o(tx),
        .erase_o(ereq), .erase_done_i(done), .erase_err_i(err),
        .prog_state_o(prog_state), .busy_o(busy));
    flash_erase_model i_flash (.clk_i(clk_i), .clr_i(clr), .req_i(ereq), .fail_i(fail),
        .dly_i(dly), .done_o(done), .err_o(err), .busy_o(ebusy), .hist_o(hist));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic [7:0] b);
        @(negedge clk_i);
        rx_valid_i = 1'b1;
        rx_data_i = b;
        @(negedge clk_i);
        rx_valid_i = 1'b0;
    endtask : send
    // Wait for a reply byte, stall the transmitter, then take it
    task automatic take(input logic [7:0] exp, input logic [7:0] stall);
        int i;
        i = 0;
        while (tx.valid !== 1'b1 && i < 400) begin
            @(negedge clk_i);
            i++;
        end
        repeat (stall) @(negedge clk_i);
        chk({7'h00, tx.valid}, 8'h01);
        chk(tx.data, exp);
        tx_ready_i = 1'b1;
        @(negedge clk_i);
        tx_ready_i = 1'b0;
    endtask : take
    task automatic run(input row_t r);
        fail = r.fail;
        dly = r.dly;
        clr = 1'b1;
        send(SEL_DEVICE);
        send(SEL_CLOCK);
        send(SEL_RATE);
        send(8'h40);
        clr = 1'b0;
        take(r.b0, r.dly);
        if (r.two) take(r.b1, 8'h00);
        @(negedge clk_i);
        chk({4'h0, hist}, {4'h0, r.hist});
        chk({6'h00, busy, prog_state}, {6'h00, 1'b0, r.prog});
    endtask : run
    task automatic finish_test;
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // Nothing may be sent while an erase runs
    always @(posedge clk_i) if (ebusy && tx.valid === 1'b1) chk(8'h01, 8'h00);
    initial begin
        #200000;
        fail_count++;
        finish_test;
    end
    initial begin
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk({3'h0, tx.valid, ereq, prog_state, busy}, 8'h00);
        foreach (rows[k]) run(rows[k]);
        // Programming data only after entry was acknowledged; command now ignored
        clr = 1'b1;
        send(8'h40);
        clr = 1'b0;
        repeat (8) @(negedge clk_i);
        chk({3'h0, busy, hist}, 8'h00);
        // Reset in mid-run leaves the programming state
        sys_rst_i = 1'b1;
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk({7'h00, prog_state}, 8'h00);
        // Any other code starts nothing
        send(8'h41);
        repeat (8) @(negedge clk_i);
        chk({3'h0, busy, hist}, 8'h00);
        // Repeat while busy is dropped, one reply only
        dly = 8'h1E;
        send(8'h40);
        send(8'h40);
        take(8'h06, 8'h03);
        repeat (8) @(negedge clk_i);
        chk({tx.valid, busy, prog_state, 1'b0, hist}, 8'h2B);
        finish_test;
    end
endmodule : test_boot_erase_state_transition
